// file: sim/tb_pdreg_bank.sv
// Self-checking bench for the diagnostic register bank over APB.
// Assumes the bank answers each access through pready and carries its
// own assertions; the bench drives all other ports directly.
`timescale 1ns/1ps

module tb_pdreg_bank;
  import pdreg_pkg::*;

  // ****************************************************************
  // Clock, reset and port signals.
  // ****************************************************************
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, irq_out, bist_tx_en_out;
  logic refl_start_out, phy_hard_reset_out, phy_restart_out;
  logic phy_standby_out;
  logic por_done_in = 1'b0;
  logic no_frame_in = 1'b0;
  logic low_power_state_event_in = 1'b0;
  logic prbs_err_byte_in = 1'b0;
  logic err_wrap_mode_in = 1'b0;
  logic bist_run_in = 1'b0;
  logic refl_done_in = 1'b0;
  logic refl_fail_in = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int n_start = 0;
  int n_hard = 0;
  int n_soft = 0;
  int hi_n, lo_n, k;
  logic [31:0] rd_v;
  logic err_v;

  always #10 clk_in = ~clk_in;

  // Pulse outputs are counted rather than caught, so their exact cycle
  // does not depend on where a bus task happens to be waiting.
  always @(posedge clk_in) begin
    if (refl_start_out === 1'b1) n_start <= n_start + 1;
    if (phy_hard_reset_out === 1'b1) n_hard <= n_hard + 1;
    if (phy_restart_out === 1'b1) n_soft <= n_soft + 1;
  end

  pdreg_bank DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .por_done_in(por_done_in),
    .no_frame_in(no_frame_in),
    .low_power_state_event_in(low_power_state_event_in),
    .irq_out(irq_out), .prbs_err_byte_in(prbs_err_byte_in),
    .err_wrap_mode_in(err_wrap_mode_in), .bist_run_in(bist_run_in),
    .bist_tx_en_out(bist_tx_en_out), .refl_start_out(refl_start_out),
    .refl_done_in(refl_done_in), .refl_fail_in(refl_fail_in),
    .phy_hard_reset_out(phy_hard_reset_out),
    .phy_restart_out(phy_restart_out),
    .phy_standby_out(phy_standby_out)
  );

  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    // Only the watchdog ends a wait for the answer.
    while (pready_out !== 1'b1) begin
      @(posedge clk_in);
    end
    rd_v = prdata_out;
    err_v = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, {16'h0, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    apb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
    chk(rd_v, {16'h0, e});
  endtask

  task automatic errs(input int n);
    @(posedge clk_in);
    prbs_err_byte_in <= 1'b1;
    repeat (n - 1) @(posedge clk_in);
    @(posedge clk_in);
    prbs_err_byte_in <= 1'b0;
  endtask

  task automatic ev(input int sel, input logic v);
    @(posedge clk_in);
    case (sel)
      0: por_done_in <= v;
      1: no_frame_in <= v;
      2: low_power_state_event_in <= v;
      3: refl_done_in <= v;
      default: refl_fail_in <= v;
    endcase
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(IDX_INT3, 16'h0010);
    rd(IDX_BIST1, 16'h007d);
    rd(IDX_BIST2, 16'h05ee);
    rd(IDX_REFL, 16'h0000);
    rd(IDX_RSTC, 16'h0000);
    rd(8'h10, 16'h0000);
    chk({31'h0, err_v}, 32'h1);
    // Interrupt events, masking and clear on read.
    ev(0, 1'b1);
    ev(0, 1'b0);
    settle();
    chk({31'h0, irq_out}, 32'h1);
    rd(IDX_INT3, 16'h1010);
    rd(IDX_INT3, 16'h0010);
    settle();
    chk({31'h0, irq_out}, 32'h0);
    wr(IDX_INT3, 16'h0009);
    rd(IDX_INT3, 16'h0009);
    ev(1, 1'b1);
    ev(1, 1'b0);
    settle();
    chk({31'h0, irq_out}, 32'h1);
    rd(IDX_INT3, 16'h0809);
    ev(2, 1'b1);
    ev(2, 1'b0);
    rd(IDX_INT3, 16'h0109);
    rd(IDX_INT3, 16'h0009);
    ev(0, 1'b1);
    settle();
    chk({31'h0, irq_out}, 32'h0);
    rd(IDX_INT3, 16'h1009);
    rd(IDX_INT3, 16'h1009);
    ev(0, 1'b0);
    rd(IDX_INT3, 16'h1009);
    rd(IDX_INT3, 16'h0009);
    // A low clock enable freezes the bank, so an event then is lost.
    @(posedge clk_in);
    ce_in <= 1'b0;
    ev(1, 1'b1);
    ev(1, 1'b0);
    settle();
    chk({31'h0, irq_out}, 32'h0);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd(IDX_INT3, 16'h0009);
    // Error counter: count, lock and clear, saturate, wrap.
    errs(5);
    wr(IDX_BIST1, 16'h807d);
    rd(IDX_BIST1, 16'h057d);
    wr(IDX_BIST1, 16'h807d);
    rd(IDX_BIST1, 16'h007d);
    errs(300);
    wr(IDX_BIST1, 16'h807d);
    rd(IDX_BIST1, 16'hff7d);
    err_wrap_mode_in <= 1'b1;
    errs(258);
    wr(IDX_BIST1, 16'h807d);
    rd(IDX_BIST1, 16'h027d);
    // Generator packet length and gap.
    wr(IDX_BIST1, 16'h0002);
    wr(IDX_BIST2, 16'h0005);
    rd(IDX_BIST2, 16'h0005);
    bist_run_in <= 1'b1;
    k = 0;
    @(negedge clk_in);
    while (bist_tx_en_out !== 1'b1 && k < 50) begin
      k++;
      @(negedge clk_in);
    end
    for (int p = 0; p < 2; p++) begin
      hi_n = 0;
      lo_n = 0;
      while (bist_tx_en_out === 1'b1 && hi_n < 50) begin
        hi_n++;
        @(negedge clk_in);
      end
      while (bist_tx_en_out === 1'b0 && lo_n < 50) begin
        lo_n++;
        @(negedge clk_in);
      end
      chk(hi_n, 32'd5);
      chk(lo_n, 32'd8);
    end
    @(posedge clk_in);
    bist_run_in <= 1'b0;
    settle();
    chk({31'h0, bist_tx_en_out}, 32'h0);
    // Cable measurement: done, then fail, start ignored while running.
    wr(IDX_REFL, 16'h8000);
    rd(IDX_REFL, 16'h8000);
    wr(IDX_REFL, 16'h8000);
    chk(n_start, 32'd1);
    ev(3, 1'b1);
    ev(3, 1'b0);
    rd(IDX_REFL, 16'h0002);
    wr(IDX_REFL, 16'h8000);
    rd(IDX_REFL, 16'h8000);
    ev(4, 1'b1);
    ev(4, 1'b0);
    rd(IDX_REFL, 16'h0001);
    chk(n_start, 32'd2);
    // Reset control: standby, restart, then a full register reset.
    wr(IDX_RSTC, 16'h0080);
    settle();
    chk({31'h0, phy_standby_out}, 32'h1);
    wr(IDX_RSTC, 16'h4080);
    rd(IDX_RSTC, 16'h0080);
    chk(n_soft, 32'd1);
    rd(IDX_INT3, 16'h0009);
    chk(n_hard, 32'd0);
    wr(IDX_RSTC, 16'h8080);
    rd(IDX_RSTC, 16'h0000);
    chk(n_hard, 32'd1);
    chk({31'h0, phy_standby_out}, 32'h0);
    rd(IDX_INT3, 16'h0010);
    rd(IDX_BIST1, 16'h007d);
    rd(IDX_BIST2, 16'h05ee);
    final_report();
  end
endmodule

// file: verilog/pdreg_bank.sv
// Diagnostic register bank: event interrupts, self-test control, cable
// measurement control and PHY reset control, reached over APB.
// Assumes APB3 signalling on clk_in; event and result inputs are
// synchronous pulses or levels from the PHY core.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

module pdreg_bank (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pdreg_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic por_done_in,
  input wire logic no_frame_in,
  input wire logic low_power_state_event_in,
  output logic irq_out,
  input wire logic prbs_err_byte_in,
  input wire logic err_wrap_mode_in,
  input wire logic bist_run_in,
  output logic bist_tx_en_out,
  output logic refl_start_out,
  input wire logic refl_done_in,
  input wire logic refl_fail_in,
  output logic phy_hard_reset_out,
  output logic phy_restart_out,
  output logic phy_standby_out
);
  import pdreg_pkg::*;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    idx_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic [GAP_W-1:0] gap_bytes(input logic [7:0] ipg);
    gap_bytes = {ipg, GAP_SHIFT_PAD};
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [EVT_W-1:0] st_r;
  logic [EVT_W-1:0] st_nxt;
  logic [EVT_W-1:0] en_r;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] rd_cap_r;
  logic [7:0] ipg_r;
  logic [PLEN_W-1:0] plen_r;
  logic refl_run_r;
  logic refl_done_r;
  logic refl_fail_r;
  logic refl_start_r;
  logic hard_r;
  logic soft_r;
  logic stby_r;
  logic irq_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  pdreg_bist_e bst_r;
  pdreg_bist_e bst_nxt;
  logic [PLEN_W-1:0] bcnt_r;
  logic [PLEN_W-1:0] bcnt_nxt;
  logic tx_en_r;
  pdreg_cnt_if cnt_if ();

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire setup = psel_in && !penable_in;
  wire acc = psel_in && penable_in && pready_r;
  wire wr = acc && pwrite_in;
  wire rd = acc && !pwrite_in;
  wire hit_int3 = idx_hit(paddr_in, IDX_INT3);
  wire hit_bist1 = idx_hit(paddr_in, IDX_BIST1);
  wire hit_bist2 = idx_hit(paddr_in, IDX_BIST2);
  wire hit_refl = idx_hit(paddr_in, IDX_REFL);
  wire hit_rstc = idx_hit(paddr_in, IDX_RSTC);
  wire hit_any = hit_int3 || hit_bist1 || hit_bist2 || hit_refl || hit_rstc;
  wire wr_int3 = wr && hit_int3;
  wire wr_bist1 = wr && hit_bist1;
  wire wr_bist2 = wr && hit_bist2;
  wire wr_refl = wr && hit_refl;
  wire wr_rstc = wr && hit_rstc;
  wire int_rdclr = rd && hit_int3;
  wire refl_go = wr_refl && pwdata_in[REFL_START] && !refl_run_r;
  // The hard reset bit returns every register here to its default.
  wire srst = hard_r;

  logic [15:0] int3_view;
  logic [15:0] bist1_view;
  logic [15:0] refl_view;
  logic [15:0] rstc_view;
  logic [15:0] rd_mux;

  always_comb begin
    int3_view = 16'h0000;
    int3_view[ST_POR] = st_r[EV_POR];
    int3_view[ST_NOF] = st_r[EV_NOF];
    int3_view[ST_LOWP] = st_r[EV_LOWP];
    int3_view[EN_POR] = en_r[EV_POR];
    int3_view[EN_NOF] = en_r[EV_NOF];
    int3_view[EN_LOWP] = en_r[EV_LOWP];
    bist1_view = {cnt_if.locked, ipg_r};
    refl_view = 16'h0000;
    refl_view[REFL_START] = refl_run_r;
    refl_view[REFL_DONE] = refl_done_r;
    refl_view[REFL_FAIL] = refl_fail_r;
    rstc_view = 16'h0000;
    rstc_view[RST_HARD] = hard_r;
    rstc_view[RST_SOFT] = soft_r;
    rstc_view[RST_STBY] = stby_r;
  end

  assign rd_mux = hit_int3 ? int3_view :
                  hit_bist1 ? bist1_view :
                  hit_bist2 ? {5'h00, plen_r} :
                  hit_refl ? refl_view :
                  hit_rstc ? rstc_view : 16'h0000;

  // ****************************************************************
  // APB slave: one wait-free access phase after every setup.
  // ****************************************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      rd_cap_r <= '0;
    end else if (ce_in) begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      if (setup) begin
        prdata_r <= {16'h0000, rd_mux};
        rd_cap_r <= st_r;
      end
    end
  end

  // ****************************************************************
  // Interrupt status and enables.
  // ****************************************************************
  assign evt = {por_done_in, no_frame_in, low_power_state_event_in};
  // Only bits the read actually returned are cleared, and a live event
  // overrides the clear, so nothing is lost between setup and access.
  assign st_nxt = (st_r & ~(int_rdclr ? rd_cap_r : '0)) | evt;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      en_r <= EN_RST;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      if (srst) begin
        st_r <= '0;
        en_r <= EN_RST;
      end else begin
        st_r <= st_nxt;
        if (wr_int3) begin
          en_r <= {pwdata_in[EN_POR], pwdata_in[EN_NOF], pwdata_in[EN_LOWP]};
        end
      end
      irq_r <= |(st_r & en_r);
    end
  end

  // ****************************************************************
  // Self-test configuration and error counter.
  // ****************************************************************
  assign cnt_if.err_byte = prbs_err_byte_in;
  assign cnt_if.sat_mode = !err_wrap_mode_in;
  assign cnt_if.lock = wr_bist1 && pwdata_in[LOCK_BIT];
  assign cnt_if.clr = srst;

  pdreg_errcnt u_errcnt (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .cnt_io(cnt_if.counter)
  );

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ipg_r <= IPG_RST;
      plen_r <= PLEN_RST;
    end else if (ce_in) begin
      if (srst) begin
        ipg_r <= IPG_RST;
        plen_r <= PLEN_RST;
      end else begin
        if (wr_bist1) begin
          ipg_r <= pwdata_in[IPG_HI:0];
        end
        if (wr_bist2) begin
          plen_r <= pwdata_in[PLEN_W-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // Self-test packet generator, one byte per enabled cycle.
  // ****************************************************************
  wire [GAP_W-1:0] gap_len = gap_bytes(ipg_r);
  wire pkt_last = (bcnt_r == plen_r - 11'h001);
  wire gap_last = (bcnt_r == {1'b0, gap_len} - 11'h001);
  wire to_pkt = (plen_r != 11'h000);

  always_comb begin
    bst_nxt = bst_r;
    bcnt_nxt = bcnt_r + 11'h001;
    unique case (bst_r)
      BIST_IDLE: begin
        bcnt_nxt = 11'h000;
        if (bist_run_in) begin
          bst_nxt = to_pkt ? BIST_PKT : BIST_GAP;
        end
      end
      BIST_PKT: begin
        if (pkt_last) begin
          bcnt_nxt = 11'h000;
          bst_nxt = (gap_len != 10'h000) ? BIST_GAP : BIST_PKT;
        end
      end
      BIST_GAP: begin
        if (gap_len == 10'h000 || gap_last) begin
          bcnt_nxt = 11'h000;
          bst_nxt = to_pkt ? BIST_PKT : BIST_GAP;
        end
      end
      default: bst_nxt = BIST_IDLE;
    endcase
    if (!bist_run_in || srst) begin
      bst_nxt = BIST_IDLE;
      bcnt_nxt = 11'h000;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bst_r <= BIST_IDLE;
      bcnt_r <= 11'h000;
      tx_en_r <= 1'b0;
    end else if (ce_in) begin
      bst_r <= bst_nxt;
      bcnt_r <= bcnt_nxt;
      tx_en_r <= (bst_nxt == BIST_PKT);
    end
  end

  // ****************************************************************
  // Cable measurement control. A start while one runs is ignored.
  // ****************************************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      refl_run_r <= 1'b0;
      refl_done_r <= 1'b0;
      refl_fail_r <= 1'b0;
      refl_start_r <= 1'b0;
    end else if (ce_in) begin
      refl_start_r <= refl_go && !srst;
      if (srst) begin
        refl_run_r <= 1'b0;
        refl_done_r <= 1'b0;
        refl_fail_r <= 1'b0;
      end else if (refl_go) begin
        refl_run_r <= 1'b1;
        refl_done_r <= 1'b0;
        refl_fail_r <= 1'b0;
      end else if (refl_run_r && (refl_done_in || refl_fail_in)) begin
        refl_run_r <= 1'b0;
        refl_done_r <= refl_done_in;
        refl_fail_r <= refl_fail_in;
      end
    end
  end

  // ****************************************************************
  // PHY reset control; both reset bits are single-cycle pulses.
  // ****************************************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hard_r <= 1'b0;
      soft_r <= 1'b0;
      stby_r <= 1'b0;
    end else if (ce_in) begin
      hard_r <= wr_rstc && pwdata_in[RST_HARD] && !hard_r;
      soft_r <= wr_rstc && pwdata_in[RST_SOFT] && !hard_r;
      if (srst) begin
        stby_r <= 1'b0;
      end else if (wr_rstc) begin
        stby_r <= pwdata_in[RST_STBY];
      end
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign irq_out = irq_r;
  assign bist_tx_en_out = tx_en_r;
  assign refl_start_out = refl_start_r;
  assign phy_hard_reset_out = hard_r;
  assign phy_restart_out = soft_r;
  assign phy_standby_out = stby_r;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [PLEN_W-1:0] run_len_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_len_r <= 11'h000;
    end else if (ce_in) begin
      run_len_r <= tx_en_r ? run_len_r + 11'h001 : 11'h000;
    end
  end

  AST_POR_LATCH: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && por_done_in && !srst |=> st_r[EV_POR])
    else $error("power-on-done event not latched");

  AST_NOF_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
    st_r[EV_NOF] && !(ce_in && (int_rdclr || srst)) |=> st_r[EV_NOF])
    else $error("no-frame status dropped without a read");

  AST_LOWP_RDCLR: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && int_rdclr && rd_cap_r[EV_LOWP] && !low_power_state_event_in
    |=> !st_r[EV_LOWP])
    else $error("low-power status not cleared by read");

  AST_EN_DEFAULT: assert property (@(posedge clk_in)
    $rose(nrst_in) |-> en_r == EN_RST)
    else $error("interrupt enables not at default after reset");

  AST_IRQ: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && (|(st_r & en_r)) |=> irq_out)
    else $error("interrupt output missing");

  AST_REFL_DONE: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && refl_run_r && refl_done_in && !refl_go && !srst
    |=> !refl_run_r && refl_done_r)
    else $error("measurement done not reported");

  AST_REFL_START: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && refl_go && !srst |=> refl_run_r && refl_start_out &&
    !refl_fail_r ##1 !refl_start_out)
    else $error("measurement start not one pulse");

  AST_PKT_LEN: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(tx_en_r) && $past(bist_run_in) && $stable(plen_r)
    |-> run_len_r == plen_r)
    else $error("generated packet length wrong");

  AST_HARD_RST: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && wr_rstc && pwdata_in[RST_HARD] && !hard_r
    |=> phy_hard_reset_out ##1 (en_r == EN_RST && ipg_r == IPG_RST))
    else $error("hard reset bit did not reset registers");

  AST_SOFT_RST: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && wr_rstc && pwdata_in[RST_SOFT] && !hard_r && !wr_bist2
    |=> phy_restart_out && $stable(plen_r))
    else $error("restart pulse missing or registers lost");

  AST_STANDBY: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && wr_rstc && !srst |=> stby_r == $past(pwdata_in[RST_STBY]))
    else $error("standby bit not written");
endmodule

// file: verilog/pdreg_cnt_if.sv
// Interface between the register bank and its self-test error counter.
// Assumes both ends run on the same clock and clock enable.
`timescale 1ns/1ps

interface pdreg_cnt_if;
  logic err_byte;
  logic sat_mode;
  logic lock;
  logic clr;
  logic [7:0] locked;

  modport owner (
    output err_byte,
    output sat_mode,
    output lock,
    output clr,
    input locked
  );

  modport counter (
    input err_byte,
    input sat_mode,
    input lock,
    input clr,
    output locked
  );
endinterface

// file: verilog/pdreg_errcnt.sv
// Self-test errored-byte counter with a lock-and-clear snapshot.
// Assumes one error pulse per errored byte, synchronous to clk_in.
`timescale 1ns/1ps

module pdreg_errcnt (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  pdreg_cnt_if.counter cnt_io
);
  import pdreg_pkg::*;

  logic [7:0] run_r;
  logic [7:0] run_nxt;
  logic [7:0] locked_r;
  logic [7:0] base;
  logic at_max;

  // A lock starts the new count from zero, so an error in that cycle counts.
  assign base = cnt_io.lock ? 8'h00 : run_r;
  assign at_max = cnt_io.sat_mode && (base == ERR_MAX);
  assign run_nxt = (cnt_io.err_byte && !at_max) ? base + 8'h01 : base;
  assign cnt_io.locked = locked_r;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_r <= 8'h00;
      locked_r <= 8'h00;
    end else if (ce_in) begin
      if (cnt_io.clr) begin
        run_r <= 8'h00;
        locked_r <= 8'h00;
      end else begin
        run_r <= run_nxt;
        if (cnt_io.lock) begin
          locked_r <= run_r;
        end
      end
    end
  end

  AST_ERR_COUNT: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && cnt_io.err_byte && !cnt_io.lock && !cnt_io.clr &&
    run_r != ERR_MAX |=> run_r == $past(run_r) + 8'h01)
    else $error("error byte not counted");

  AST_LOCK_CLEAR: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && cnt_io.lock && !cnt_io.clr |=>
    locked_r == $past(run_r) && run_r <= 8'h01)
    else $error("lock did not capture and clear");

  AST_SATURATE: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ce_in && cnt_io.sat_mode && run_r == ERR_MAX && !cnt_io.lock &&
    !cnt_io.clr |=> run_r == ERR_MAX)
    else $error("counter left maximum in saturate mode");
endmodule

// file: verilog/pdreg_pkg.sv
// Constants, field layouts and types shared by the diagnostic register bank.
// Assumes an APB master with 32-bit data and one 16-bit register per word.

package pdreg_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_INT3 = 8'h18;
  localparam logic [7:0] IDX_BIST1 = 8'h1b;
  localparam logic [7:0] IDX_BIST2 = 8'h1c;
  localparam logic [7:0] IDX_REFL = 8'h1e;
  localparam logic [7:0] IDX_RSTC = 8'h1f;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EV_POR = 2;
  localparam int unsigned EV_NOF = 1;
  localparam int unsigned EV_LOWP = 0;
  localparam int unsigned ST_POR = 12;
  localparam int unsigned ST_NOF = 11;
  localparam int unsigned ST_LOWP = 8;
  localparam int unsigned EN_POR = 4;
  localparam int unsigned EN_NOF = 3;
  localparam int unsigned EN_LOWP = 0;
  localparam int unsigned ERR_HI = 15;
  localparam int unsigned ERR_LO = 8;
  localparam int unsigned LOCK_BIT = 15;
  localparam int unsigned IPG_HI = 7;
  localparam int unsigned PLEN_W = 11;
  localparam int unsigned GAP_W = 10;
  localparam int unsigned REFL_START = 15;
  localparam int unsigned REFL_DONE = 1;
  localparam int unsigned REFL_FAIL = 0;
  localparam int unsigned RST_HARD = 15;
  localparam int unsigned RST_SOFT = 14;
  localparam int unsigned RST_STBY = 7;

  // ****************************************************************
  // Reset values and limits.
  // ****************************************************************
  localparam logic [EVT_W-1:0] EN_RST = 3'h4;
  localparam logic [7:0] IPG_RST = 8'h7d;
  localparam logic [10:0] PLEN_RST = 11'h5ee;
  localparam logic [7:0] ERR_MAX = 8'hff;
  localparam logic [1:0] GAP_SHIFT_PAD = 2'h0;

  typedef enum logic [1:0] {
    BIST_IDLE,
    BIST_PKT,
    BIST_GAP
  } pdreg_bist_e;

endpackage
